/* rtl/fir_map.svh */
// register map, field positions and fixed figures of the fir decimator
//
// Function
// - always filter, store only after start
// - tap count is a build parameter, 128/512
// - four enableable groups of four channels
// - private delay lines, shared group coefficients
// - new sample enters newest delay position first
// - output is sum of products shifted down 22 bits, saturated
// - advance delay line after each output
// - enabled filter with a preset set delays half the tap count
// - channel path adds one sample latency outside scan mode
// - custom coefficients with programmable tap count
// - ten preset coefficient sets, index 0-9
// - preset cutoff halves per index, 9 equals 8, 128-tap build stops at 7
// - preset nine is a moving average
// - decimation on 128-tap build, zero keeps all
// - filter runs at converter rate always
// - decimation ratio in power-of-two steps to 512
// - onboard rate within one octave of 120 kHz
// - scan mode filter still runs at converter rate
// - disabled group passes samples straight through
// - scan mode holds value, stores on scan edge
`ifndef FIR_MAP_SVH
`define FIR_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define REG_CTRL      12'h000
`define REG_TAPS      12'h004
`define REG_COEF_ADDR 12'h008
`define REG_COEF_DATA 12'h00c
`define REG_STATUS    12'h010

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define CTRL_EN_LSB    0
`define CTRL_START     4
`define CTRL_SCAN      5
`define CTRL_CUSTOM    6
`define CTRL_STOP      7
`define CTRL_IDX_LSB   8
`define CTRL_DEC_LSB   12
`define COEF_GRP_LSB   12

// ----------------------------------------------------------------
// sizes and figures
// ----------------------------------------------------------------
`define CHANNELS      16
`define GROUPS        4
`define DATA_W        24
`define ACC_W         58
`define TAPS_LOW      128
`define TAPS_SHARP    512
`define UNITY_SHIFT   22
`define COEF_UNITY    24'h400000
`define PRESET_CAP    4'h8
`define DECIM_MAX     4'h9

`endif

/* rtl/fir_pkg.sv */
// types shared by the fir decimator
`default_nettype none
package fir_pkg;

    typedef struct packed
    {
        logic [3:0]         chan;
        logic signed [23:0] data;
    } sample_t;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b01,
        ST_MAC  = 2'b10
    } eng_state_t;

endpackage
`default_nettype wire

/* rtl/multichannel_fir_decimator.sv */
// sixteen-channel fir filter with decimation and start gating
//
// Local design decisions: the placing of the registers and the APB slave port.
`include "fir_map.svh"
`default_nettype none
module multichannel_fir_decimator
#(
    parameter int TAPS = `TAPS_LOW
)
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              in_valid,
    input  wire fir_pkg::sample_t  in_sample,
    output logic                   in_ready,
    input  wire logic              start_trigger,
    input  wire logic              scan_clock,
    output logic                   out_valid,
    output fir_pkg::sample_t       out_sample
);

    localparam int PW = $clog2(TAPS);
    localparam logic [3:0] TAP_LOG = 4'(PW);
    localparam logic [9:0] HALF = 10'(TAPS / 2);
    localparam logic [PW-1:0] LAST = PW'(TAPS - 1);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic signed [23:0] sat24
    (
        input logic signed [`ACC_W-1:0] a
    );
        logic signed [`ACC_W-1:0] s;
        s = a >>> `UNITY_SHIFT;
        if (&s[`ACC_W-1:23] || ~|s[`ACC_W-1:23])
            sat24 = s[23:0];
        else if (s[`ACC_W-1])
            sat24 = 24'h800000;
        else
            sat24 = 24'h7fffff;
    endfunction

    // centred boxcar: delay stays at half the tap count for every index
    function automatic logic signed [23:0] preset_coef
    (
        input logic [3:0] idx,
        input logic [9:0] k
    );
        logic [3:0] n;
        logic [9:0] len;
        logic [9:0] lo;
        n = (idx > `PRESET_CAP) ? `PRESET_CAP : idx;
        if (n > TAP_LOG)
            n = TAP_LOG;
        len = 10'h001 << n;
        lo = HALF - (len >> 1);
        if (k >= lo && k < lo + len)
            preset_coef = `COEF_UNITY >> n;
        else
            preset_coef = 24'h000000;
    endfunction

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [3:0]  enable_reg;
    logic        scan_clock_gating_flag;
    logic        custom_reg;
    logic [3:0]  index_reg;
    logic [3:0]  decim_reg;
    logic [9:0]  taps_reg;
    logic [1:0]  cgrp_reg;
    logic [PW-1:0] ctap_reg;
    logic        storing_reg;
    logic [31:0] prdata_reg;
    logic        trig_s1_reg;
    logic        trig_s2_reg;
    logic        trig_d_reg;
    logic        scan_s1_reg;
    logic        scan_s2_reg;
    logic        scan_d_reg;
    logic signed [23:0] cmem [`GROUPS][TAPS];
    logic [15:0] idle;
    logic [15:0] emit;
    logic [23:0] chval [`CHANNELS];
    logic [15:0] pend_reg;
    logic [15:0] pend_clr;
    logic [3:0]  sel;
    logic        out_valid_reg;
    fir_pkg::sample_t out_reg;

    logic wr_en;
    logic rd_setup;
    logic mapped;
    logic [31:0] rdata;
    logic trig_edge;
    logic scan_edge;
    logic [PW-1:0] ntaps_m1;
    logic [3:0] decim_eff;

    assign wr_en = psel && penable && pwrite && mapped;
    assign rd_setup = psel && !penable;
    assign mapped = paddr == `REG_CTRL || paddr == `REG_TAPS ||
                    paddr == `REG_COEF_ADDR || paddr == `REG_COEF_DATA ||
                    paddr == `REG_STATUS;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_reg;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            enable_reg <= 4'h0;
            scan_clock_gating_flag <= 1'b0;
            custom_reg <= 1'b0;
            index_reg <= 4'h0;
            decim_reg <= 4'h0;
        end
        else if (wr_en && paddr == `REG_CTRL)
        begin
            enable_reg <= pwdata[`CTRL_EN_LSB +: 4];
            scan_clock_gating_flag <= pwdata[`CTRL_SCAN];
            custom_reg <= pwdata[`CTRL_CUSTOM];
            index_reg <= pwdata[`CTRL_IDX_LSB +: 4];
            decim_reg <= pwdata[`CTRL_DEC_LSB +: 4];
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            taps_reg <= 10'h000;
        else if (wr_en && paddr == `REG_TAPS)
            taps_reg <= pwdata[9:0];
    end

    // coefficient upload, address steps on each data write
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            cgrp_reg <= 2'h0;
            ctap_reg <= '0;
        end
        else if (wr_en && paddr == `REG_COEF_ADDR)
        begin
            cgrp_reg <= pwdata[`COEF_GRP_LSB +: 2];
            ctap_reg <= pwdata[PW-1:0];
        end
        else if (wr_en && paddr == `REG_COEF_DATA)
            ctap_reg <= ctap_reg + 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (wr_en && paddr == `REG_COEF_DATA)
            cmem[cgrp_reg][ctap_reg] <= pwdata[23:0];
    end

    // ----------------------------------------------------------------
    // start gating
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            trig_s1_reg <= 1'b0;
            trig_s2_reg <= 1'b0;
            trig_d_reg <= 1'b0;
            scan_s1_reg <= 1'b0;
            scan_s2_reg <= 1'b0;
            scan_d_reg <= 1'b0;
        end
        else
        begin
            trig_s1_reg <= start_trigger;
            trig_s2_reg <= trig_s1_reg;
            trig_d_reg <= trig_s2_reg;
            scan_s1_reg <= scan_clock;
            scan_s2_reg <= scan_s1_reg;
            scan_d_reg <= scan_s2_reg;
        end
    end

    assign trig_edge = trig_s2_reg && !trig_d_reg;
    assign scan_edge = scan_s2_reg && !scan_d_reg;

    // start beats stop when both land together
    always_ff @(posedge clk)
    begin
        if (reset)
            storing_reg <= 1'b0;
        else if (trig_edge || (wr_en && paddr == `REG_CTRL &&
                 pwdata[`CTRL_START]))
            storing_reg <= 1'b1;
        else if (wr_en && paddr == `REG_CTRL && pwdata[`CTRL_STOP])
            storing_reg <= 1'b0;
    end

    always_comb
    begin
        rdata = 32'h00000000;
        unique case (paddr)
            `REG_CTRL:
                rdata = {16'h0000, decim_reg, index_reg, 1'b0, custom_reg,
                         scan_clock_gating_flag, 1'b0, enable_reg};
            `REG_TAPS:
                rdata = {22'h000000, taps_reg};
            `REG_COEF_ADDR:
                rdata = {18'h00000, cgrp_reg, 12'(ctap_reg)};
            `REG_STATUS:
                rdata = {~idle, 15'h0000, storing_reg};
            default:
                rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            prdata_reg <= 32'h00000000;
        else if (rd_setup)
            prdata_reg <= rdata;
    end

    // zero or oversize tap count falls back to the full line
    assign ntaps_m1 = (custom_reg && taps_reg != 10'h000 &&
                       taps_reg <= 10'(TAPS)) ?
                      PW'(taps_reg - 10'h001) : LAST;
    // no decimation on the long build
    assign decim_eff = (TAPS != `TAPS_LOW) ? 4'h0 :
                       (decim_reg > `DECIM_MAX) ? `DECIM_MAX :
                       decim_reg;

    // ----------------------------------------------------------------
    // channel engines
    // ----------------------------------------------------------------
    for (genvar c = 0; c < `CHANNELS; c++)
    begin : ch
        localparam int G = c / 4;
        logic signed [23:0] dl [TAPS];
        fir_pkg::eng_state_t st_reg;
        logic [PW-1:0] wp_reg;
        logic [PW-1:0] tap_reg;
        logic signed [`ACC_W-1:0] acc_reg;
        logic signed [23:0] res_reg;
        logic [23:0] val_reg;
        logic [8:0] dec_reg;
        logic take;
        logic signed [23:0] smp;
        logic signed [23:0] coef;
        logic signed [47:0] prod;
        logic signed [`ACC_W-1:0] sum;
        logic dec_hit;

        assign take = in_valid && in_sample.chan == 4'(c) &&
                      st_reg == fir_pkg::ST_IDLE;
        assign idle[c] = st_reg == fir_pkg::ST_IDLE;
        assign smp = dl[wp_reg - tap_reg];
        assign coef = custom_reg ? cmem[G][tap_reg] :
                      preset_coef(index_reg, 10'(tap_reg));
        assign prod = smp * coef;
        assign sum = acc_reg + `ACC_W'(prod);
        assign dec_hit = dec_reg == 9'h000;
        // scan mode paces stores itself, decimation is bypassed
        assign emit[c] = storing_reg && (scan_clock_gating_flag ?
                         scan_edge : take && dec_hit);
        assign chval[c] = val_reg;

        always_ff @(posedge clk)
        begin
            if (take)
                dl[wp_reg] <= in_sample.data;
        end

        // one tap per clock; 512 taps fit a 30 kHz sample period
        always_ff @(posedge clk)
        begin
            if (reset)
            begin
                st_reg <= fir_pkg::ST_IDLE;
                wp_reg <= '0;
                tap_reg <= '0;
                acc_reg <= '0;
                res_reg <= 24'h000000;
            end
            else
            begin
                unique case (st_reg)
                    fir_pkg::ST_IDLE:
                    begin
                        if (take && enable_reg[G])
                        begin
                            st_reg <= fir_pkg::ST_MAC;
                            tap_reg <= '0;
                            acc_reg <= '0;
                        end
                        else if (take)
                            res_reg <= in_sample.data;
                    end
                    fir_pkg::ST_MAC:
                    begin
                        acc_reg <= sum;
                        tap_reg <= tap_reg + 1'b1;
                        if (tap_reg == ntaps_m1)
                        begin
                            res_reg <= sat24(sum);
                            wp_reg <= wp_reg + 1'b1;
                            st_reg <= fir_pkg::ST_IDLE;
                        end
                    end
                endcase
            end
        end

        always_ff @(posedge clk)
        begin
            if (reset)
                dec_reg <= 9'h000;
            else if (take)
                dec_reg <= (dec_reg + 9'h001) &
                           9'((10'h001 << decim_eff) - 10'h001);
        end

        // outside scan mode the released value is the previous result: one sample behind
        always_ff @(posedge clk)
        begin
            if (reset)
                val_reg <= 24'h000000;
            else if (emit[c])
                val_reg <= res_reg;
        end
    end

    assign in_ready = idle[in_sample.chan];

    // ----------------------------------------------------------------
    // output arbitration
    // ----------------------------------------------------------------
    always_comb
    begin
        sel = 4'h0;
        pend_clr = 16'h0000;
        for (int i = `CHANNELS - 1; i >= 0; i--)
        begin
            if (pend_reg[i])
                sel = 4'(i);
        end
        if (|pend_reg)
            pend_clr[sel] = 1'b1;
    end

    // fresh store beats the clear in the same cycle
    always_ff @(posedge clk)
    begin
        if (reset)
            pend_reg <= 16'h0000;
        else
            pend_reg <= (pend_reg & ~pend_clr) | emit;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            out_valid_reg <= 1'b0;
            out_reg <= '0;
        end
        else
        begin
            out_valid_reg <= |pend_reg;
            if (|pend_reg)
            begin
                out_reg.chan <= sel;
                out_reg.data <= chval[sel];
            end
        end
    end

    assign out_valid = out_valid_reg;
    assign out_sample = out_reg;

endmodule
`default_nettype wire

/* tb/adc_stream_model.sv */
// converter source and output buffer sink facing the fir decimator
`default_nettype none
module adc_stream_model
(
    input  wire logic             clk,
    input  wire logic             in_ready,
    input  wire logic             out_valid,
    input  wire fir_pkg::sample_t out_sample,
    output var logic              in_valid,
    output fir_pkg::sample_t      in_sample
);
    timeunit 1ns;
    timeprecision 1ps;
    int          cnt = 0;
    logic [23:0] last [16];
    initial
    begin
        in_valid  = 1'b0;
        in_sample = '0;
    end
    // one word paced at the converter rate, held until taken
    task automatic push(input logic [3:0] ch, input logic [23:0] d);
        @(posedge clk);
        in_valid  <= 1'b1;
        in_sample <= {ch, d};
        do
            @(posedge clk);
        while (in_ready !== 1'b1);
        in_valid  <= 1'b0;
        // inverted, so a stale word never passes for fresh data
        in_sample <= ~{ch, d};
    endtask
    // output buffer never pushes back
    always @(posedge clk)
    begin
        if (out_valid === 1'b1)
        begin
            cnt <= cnt + 1;
            last[out_sample.chan] <= out_sample.data;
        end
    end
endmodule
`default_nettype wire

/* tb/fir_props.sv */
// port assertions for the fir decimator
`include "fir_map.svh"
`default_nettype none
module fir_props
#(
    parameter int TAPS = 128
)
(
    input wire logic             clk,
    input wire logic             reset,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      pwdata,
    input wire logic             pready,
    input wire logic [31:0]      prdata,
    input wire logic             pslverr,
    input wire logic             in_valid,
    input wire fir_pkg::sample_t in_sample,
    input wire logic             in_ready,
    input wire logic             start_trigger,
    input wire logic             scan_clock,
    input wire logic             out_valid,
    input wire fir_pkg::sample_t out_sample
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        acc_ok, wr_ctrl, scan_sh, store_sh, seen_sh, cus_sh;
    logic [3:0]  en_sh, dec_sh, tk_chan;
    logic [15:0] had;
    logic [9:0]  tk_age, tp_sh, nt_sh;
    assign acc_ok  = paddr inside {`REG_CTRL, `REG_TAPS, `REG_COEF_ADDR,
                                   `REG_COEF_DATA, `REG_STATUS};
    assign wr_ctrl = psel && penable && pwrite && paddr == `REG_CTRL;
    // busy span follows the custom tap count when one is in use
    assign nt_sh   = (cus_sh && tp_sh != 10'h0 && tp_sh <= 10'(TAPS)) ?
                     tp_sh : 10'(TAPS);
    // ----
    // shadows of control state
    // ----
    always_ff @(posedge clk)
    begin
        if (reset)
            {en_sh, dec_sh, scan_sh, cus_sh, tp_sh} <= 20'h0;
        else if (wr_ctrl)
            {en_sh, dec_sh, scan_sh, cus_sh} <= {pwdata[3:0], pwdata[15:12],
                                                 pwdata[5], pwdata[6]};
        else if (psel && penable && pwrite && paddr == `REG_TAPS)
            tp_sh <= pwdata[9:0];
    end
    // level of the trigger is enough: the design's sync only lags
    always_ff @(posedge clk)
    begin
        if (reset)
            {store_sh, seen_sh} <= 2'b00;
        else if (start_trigger || (wr_ctrl && pwdata[4]))
            {store_sh, seen_sh} <= 2'b11;
        else if (wr_ctrl && pwdata[7])
            store_sh <= 1'b0;
    end
    always_ff @(posedge clk)
    begin
        if (reset)
            {had, tk_chan, tk_age} <= {16'h0, 4'h0, 10'h3ff};
        else if (in_valid && in_ready)
        begin
            had[in_sample.chan] <= 1'b1;
            {tk_chan, tk_age}   <= {in_sample.chan, 10'h0};
        end
        else if (tk_age != 10'h3ff)
            tk_age <= tk_age + 10'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_take;
        in_valid && in_ready;
    endsequence
    sequence s_scan_edge;
        scan_sh && store_sh && $rose(scan_clock);
    endsequence
    a_reset_quiet: assert property (
        $fell(reset) |-> !out_valid && in_ready && prdata == 32'h0)
        else $error("outputs not quiet after reset");
    a_no_early_store: assert property (
        !seen_sh |-> !out_valid) else $error("output before any start");
    a_busy_refuse: assert property (
        in_valid && in_sample.chan == tk_chan && en_sh[tk_chan[3:2]]
        && tk_age < nt_sh |-> !in_ready)
        else $error("sample taken while filter busy");
    a_bypass_ready: assert property (
        in_valid && !en_sh[in_sample.chan[3:2]] |-> in_ready)
        else $error("bypass channel refused a sample");
    a_bypass_emit: assert property (
        s_take ##0 (!en_sh[in_sample.chan[3:2]] && store_sh && !scan_sh
        && dec_sh == 4'h0 && had[in_sample.chan]) |-> ##[2:20] out_valid)
        else $error("no output after bypass sample");
    a_scan_burst: assert property (
        s_scan_edge |-> ##[2:12] out_valid) else $error("no scan output");
    a_bad_addr_err: assert property (
        psel && penable && !acc_ok |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_good_addr_ok: assert property (
        psel && penable && acc_ok |-> pready && !pslverr)
        else $error("mapped access refused");
endmodule
bind multichannel_fir_decimator fir_props #(.TAPS(TAPS)) u_props
(
    .clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .in_valid(in_valid),
    .in_sample(in_sample), .in_ready(in_ready),
    .start_trigger(start_trigger), .scan_clock(scan_clock),
    .out_valid(out_valid), .out_sample(out_sample)
);
`default_nettype wire

/* tb/multichannel_fir_decimator_tb.sv */
// self-checking bench for the fir decimator
`include "fir_map.svh"
`default_nettype none
module multichannel_fir_decimator_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed
    {
        logic        wr;
        logic [11:0] addr;
        logic [31:0] data, exp;
        logic        err;
    } apb_row_t;
    logic             clk, reset, psel, penable, pwrite, pready, pslverr;
    logic             in_valid, in_ready, start_trigger, scan_clock, out_valid;
    logic [11:0]      paddr;
    logic [31:0]      pwdata, prdata, rd, e;
    logic             er;
    fir_pkg::sample_t in_sample, out_sample;
    int               error_cnt = 0, samples_checked = 0, c0;
    apb_row_t         rows [9] = '{
        '{1'b1, `REG_CTRL, 32'h235f, 32'h0, 1'b0},
        '{1'b0, `REG_CTRL, 32'h0, 32'h234f, 1'b0},
        '{1'b0, `REG_STATUS, 32'h0, 32'h1, 1'b0},
        '{1'b1, `REG_CTRL, 32'h80, 32'h0, 1'b0},
        '{1'b0, `REG_STATUS, 32'h0, 32'h0, 1'b0},
        '{1'b1, `REG_TAPS, 32'h40, 32'h0, 1'b0},
        '{1'b0, `REG_TAPS, 32'h0, 32'h40, 1'b0},
        '{1'b0, `REG_COEF_DATA, 32'h0, 32'h0, 1'b0},
        '{1'b0, 12'h014, 32'h0, 32'h0, 1'b1}};
    function automatic logic [23:0] xv(input int n);
        return 24'(n * 4097 + 16);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // one idle cycle between transfers keeps each signal single-driven
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    multichannel_fir_decimator #(.TAPS(`TAPS_LOW)) DUT
    (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .in_valid(in_valid),
        .in_sample(in_sample), .in_ready(in_ready),
        .start_trigger(start_trigger), .scan_clock(scan_clock),
        .out_valid(out_valid), .out_sample(out_sample)
    );
    adc_stream_model adc
    (
        .clk(clk), .in_ready(in_ready), .out_valid(out_valid),
        .out_sample(out_sample), .in_valid(in_valid), .in_sample(in_sample)
    );
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // the filter run alone needs about 18k cycles
    initial
    begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        stop_test();
    end
    initial
    begin
        {reset, psel, penable, pwrite, paddr, pwdata} = {4'h8, 12'h0, 32'h0};
        {start_trigger, scan_clock} = 2'b00;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        check({prdata[28:0], out_valid, in_ready, pslverr}, 32'h2);
        foreach (rows[i])
        begin
            apb(rows[i].wr, rows[i].addr, rows[i].data);
            check({31'h0, er}, {31'h0, rows[i].err});
            if (!rows[i].wr)
                check(rd, rows[i].exp);
        end
        // ----
        // awkward cases
        // ----
        for (int i = 0; i < 10; i++)
        begin
            apb(1'b1, `REG_CTRL, 32'(i) << 8);
            apb(1'b0, `REG_CTRL, 32'h0);
            check(rd, 32'(i) << 8);
        end
        apb(1'b1, `REG_CTRL, 32'h0);
        for (int i = 0; i < 3; i++)
            adc.push(4'h5, xv(i));
        repeat (8) @(posedge clk);
        check(32'(adc.cnt), 32'h0);
        start_trigger <= 1'b1;
        repeat (4) @(posedge clk);
        start_trigger <= 1'b0;
        repeat (4) @(posedge clk);
        apb(1'b0, `REG_STATUS, 32'h0);
        check(rd, 32'h1);
        for (int i = 3; i < 5; i++)
        begin
            adc.push(4'h5, xv(i));
            repeat (4) @(posedge clk);
            check({8'h0, adc.last[5]}, {8'h0, xv(i - 1)});
        end
        for (int d = 0; d < 4; d++)
        begin
            apb(1'b1, `REG_CTRL, 32'(d) << 12);
            c0 = adc.cnt;
            for (int i = 0; i < 8; i++)
                adc.push(4'(8 + d), xv(i));
            repeat (6) @(posedge clk);
            check(32'(adc.cnt - c0), 32'(8 >> d));
        end
        apb(1'b1, `REG_CTRL, 32'h20);
        c0 = adc.cnt;
        scan_clock <= 1'b1;
        repeat (4) @(posedge clk);
        scan_clock <= 1'b0;
        repeat (40) @(posedge clk);
        check(32'(adc.cnt - c0), 32'h10);
        check({8'h0, adc.last[5]}, {8'h0, xv(4)});
        apb(1'b1, `REG_CTRL, 32'h1);
        for (int n = 0; n < 140; n++)
        begin
            adc.push(4'h0, xv(n));
            if (n >= 134)
            begin
                repeat (4) @(posedge clk);
                e = {8'h0, xv(n - 65)};
                check({8'h0, adc.last[0]}, e);
            end
        end
        // custom set: unity at tap 1 of four; let the last mac finish first
        repeat (130) @(posedge clk);
        apb(1'b1, `REG_COEF_ADDR, 32'h0);
        for (int k = 0; k < 4; k++)
            apb(1'b1, `REG_COEF_DATA, (k == 1) ? {8'h0, `COEF_UNITY} : 32'h0);
        apb(1'b0, `REG_COEF_ADDR, 32'h0);
        check(rd, 32'h4);
        apb(1'b1, `REG_TAPS, 32'h4);
        apb(1'b1, `REG_CTRL, 32'h41);
        for (int n = 140; n < 144; n++)
        begin
            adc.push(4'h0, xv(n));
            repeat (4) @(posedge clk);
            if (n > 140)
                check({8'h0, adc.last[0]}, {8'h0, xv(n - 2)});
        end
        stop_test();
    end
endmodule
`default_nettype wire
